// File: design/cvf_pkg.sv
package cvf_pkg;

  // Bus and counter widths.
  localparam int CVF_ADDR_W = 10;
  localparam int CVF_DATA_W = 8;
  localparam int CVF_CNT_W  = 16;
  localparam int CVF_NUM_IF = 3;

  // Interface indices into the frame-valid vector and the counter arrays.
  localparam int CVF_IF_HOST  = 0;
  localparam int CVF_IF_LOWER = 1;
  localparam int CVF_IF_UPPER = 2;

  // Byte fields of a 16-bit count.
  localparam int CVF_HI_MSB = 15;
  localparam int CVF_HI_LSB = 8;
  localparam int CVF_LO_MSB = 7;
  localparam int CVF_LO_LSB = 0;

  // Count limits and reset values.
  localparam logic [CVF_CNT_W-1:0]  CVF_CNT_MAX   = 16'hFFFF;
  localparam logic [CVF_CNT_W-1:0]  CVF_CNT_ZERO  = 16'h0000;
  localparam logic [CVF_CNT_W-1:0]  CVF_CNT_ONE   = 16'h0001;
  localparam logic [CVF_DATA_W-1:0] CVF_BYTE_ZERO = 8'h00;

  // High-byte registers: host, lower chain port, upper chain port.
  localparam logic [CVF_ADDR_W-1:0] CVF_HIGH_OFS [CVF_NUM_IF] = '{10'h26B, 10'h26D, 10'h26F};

  // Low-byte registers, same order.
  localparam logic [CVF_ADDR_W-1:0] CVF_LOW_OFS [CVF_NUM_IF] = '{10'h26C, 10'h26E, 10'h270};

  // Snapshot trigger registers, same order.
  localparam logic [CVF_ADDR_W-1:0] CVF_SNAP_OFS [CVF_NUM_IF] = '{10'h265, 10'h266, 10'h267};

  // One register bus request, sampled on the rising edge of mclk.
  typedef struct packed {
    logic [CVF_ADDR_W-1:0] addr;
    logic [CVF_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } cvf_bus_req_t;

endpackage

// File: design/cvf_counters.sv
`timescale 1ns/1ps

module cvf_counters (
  input  wire logic                                 mclk,
  input  wire logic                                 rst_b,
  input  wire cvf_pkg::cvf_bus_req_t                bus_req,
  input  wire logic [cvf_pkg::CVF_NUM_IF-1:0]       frame_valid,
  output logic      [cvf_pkg::CVF_DATA_W-1:0]       rdata
);

  // True when a read strobe addresses the given offset.
  function automatic logic rd_hit(input cvf_pkg::cvf_bus_req_t req,
                                  input logic [cvf_pkg::CVF_ADDR_W-1:0] ofs);
    rd_hit = req.rd && (req.addr == ofs);
  endfunction

  // Each interface keeps a live running count and a snapshot that software reads.
  // Reading only the snapshot means the two bytes of one count can never tear apart.
  // The price is that the count registers show nothing new until the next trigger read.
  logic [cvf_pkg::CVF_CNT_W-1:0]  run_reg  [cvf_pkg::CVF_NUM_IF];
  logic [cvf_pkg::CVF_CNT_W-1:0]  snap_reg [cvf_pkg::CVF_NUM_IF];
  logic [cvf_pkg::CVF_NUM_IF-1:0] snap_hit;
  logic [cvf_pkg::CVF_DATA_W-1:0] rdata_reg;
  logic [cvf_pkg::CVF_DATA_W-1:0] rdata_next;

  // Frame-valid pulses come from the receivers on mclk, so they need no synchroniser.
  genvar gi;
  generate
    for (gi = 0; gi < cvf_pkg::CVF_NUM_IF; gi++) begin : g_if

      // A read of the interface's trigger register starts a new interval.
      assign snap_hit[gi] = rd_hit(bus_req, cvf_pkg::CVF_SNAP_OFS[gi]);

      // Running count; a frame in the snapshot cycle is kept as the first of the new interval.
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          run_reg[gi] <= cvf_pkg::CVF_CNT_ZERO;
        end else if (snap_hit[gi]) begin
          run_reg[gi] <= frame_valid[gi] ? cvf_pkg::CVF_CNT_ONE : cvf_pkg::CVF_CNT_ZERO;
        end else if (frame_valid[gi] && (run_reg[gi] != cvf_pkg::CVF_CNT_MAX)) begin
          run_reg[gi] <= run_reg[gi] + cvf_pkg::CVF_CNT_ONE;
        end
      end

      // Both bytes load from one 16-bit copy in one cycle, so high and low never mix intervals.
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          snap_reg[gi] <= cvf_pkg::CVF_CNT_ZERO;
        end else if (snap_hit[gi]) begin
          snap_reg[gi] <= run_reg[gi];
        end
      end

    end
  endgenerate

  // Read decode; writes are never decoded, so every register here ignores them.
  always_comb begin
    rdata_next = cvf_pkg::CVF_BYTE_ZERO;
    for (int i = 0; i < cvf_pkg::CVF_NUM_IF; i++) begin
      if (rd_hit(bus_req, cvf_pkg::CVF_HIGH_OFS[i])) begin
        rdata_next = snap_reg[i][cvf_pkg::CVF_HI_MSB:cvf_pkg::CVF_HI_LSB];
      end
      if (rd_hit(bus_req, cvf_pkg::CVF_LOW_OFS[i])) begin
        rdata_next = snap_reg[i][cvf_pkg::CVF_LO_MSB:cvf_pkg::CVF_LO_LSB];
      end
    end
  end

  // Read data stands only in the cycle after the strobe and is zero otherwise.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= cvf_pkg::CVF_BYTE_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

  // Lower chain port: one frame adds exactly one below full scale.
  a_lower_count_step: assert property (
    @(posedge mclk) disable iff (!rst_b)
    frame_valid[cvf_pkg::CVF_IF_LOWER] && !snap_hit[cvf_pkg::CVF_IF_LOWER]
      && run_reg[cvf_pkg::CVF_IF_LOWER] != cvf_pkg::CVF_CNT_MAX
    |=> run_reg[cvf_pkg::CVF_IF_LOWER] == $past(run_reg[cvf_pkg::CVF_IF_LOWER]) + cvf_pkg::CVF_CNT_ONE)
    else $error("lower port count did not advance by one");

  // Lower chain port: no frame, no snapshot, no change.
  a_lower_count_idle: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !frame_valid[cvf_pkg::CVF_IF_LOWER] && !snap_hit[cvf_pkg::CVF_IF_LOWER]
    |=> $stable(run_reg[cvf_pkg::CVF_IF_LOWER]))
    else $error("lower port count moved without a frame");

  // Lower chain port: full scale holds across frames.
  a_lower_sat_hold: assert property (
    @(posedge mclk) disable iff (!rst_b)
    run_reg[cvf_pkg::CVF_IF_LOWER] == cvf_pkg::CVF_CNT_MAX && !snap_hit[cvf_pkg::CVF_IF_LOWER]
    |=> run_reg[cvf_pkg::CVF_IF_LOWER] == cvf_pkg::CVF_CNT_MAX)
    else $error("lower port count left full scale without a snapshot");

  // Lower chain port: snapshot copies the count and restarts it.
  a_lower_snap_clear: assert property (
    @(posedge mclk) disable iff (!rst_b)
    snap_hit[cvf_pkg::CVF_IF_LOWER]
    |=> snap_reg[cvf_pkg::CVF_IF_LOWER] == $past(run_reg[cvf_pkg::CVF_IF_LOWER])
      && run_reg[cvf_pkg::CVF_IF_LOWER]
         == ($past(frame_valid[cvf_pkg::CVF_IF_LOWER]) ? cvf_pkg::CVF_CNT_ONE : cvf_pkg::CVF_CNT_ZERO))
    else $error("lower port snapshot did not copy and clear");

  // Snapshot registers of every interface change only on their own trigger read.
  a_snap_held_host: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !snap_hit[cvf_pkg::CVF_IF_HOST] |=> $stable(snap_reg[cvf_pkg::CVF_IF_HOST]))
    else $error("host snapshot changed outside a trigger read");

  a_snap_held_lower: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !snap_hit[cvf_pkg::CVF_IF_LOWER] |=> $stable(snap_reg[cvf_pkg::CVF_IF_LOWER]))
    else $error("lower port snapshot changed outside a trigger read");

  a_snap_held_upper: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !snap_hit[cvf_pkg::CVF_IF_UPPER] |=> $stable(snap_reg[cvf_pkg::CVF_IF_UPPER]))
    else $error("upper port snapshot changed outside a trigger read");

  // Host interface: one frame adds one below full scale, and full scale holds.
  a_host_count_step: assert property (
    @(posedge mclk) disable iff (!rst_b)
    frame_valid[cvf_pkg::CVF_IF_HOST] && !snap_hit[cvf_pkg::CVF_IF_HOST]
    |=> run_reg[cvf_pkg::CVF_IF_HOST]
        == (($past(run_reg[cvf_pkg::CVF_IF_HOST]) == cvf_pkg::CVF_CNT_MAX) ? cvf_pkg::CVF_CNT_MAX
            : $past(run_reg[cvf_pkg::CVF_IF_HOST]) + cvf_pkg::CVF_CNT_ONE))
    else $error("host count did not step or saturate");

  // Upper chain port: same stepping and saturation.
  a_upper_count_step: assert property (
    @(posedge mclk) disable iff (!rst_b)
    frame_valid[cvf_pkg::CVF_IF_UPPER] && !snap_hit[cvf_pkg::CVF_IF_UPPER]
    |=> run_reg[cvf_pkg::CVF_IF_UPPER]
        == (($past(run_reg[cvf_pkg::CVF_IF_UPPER]) == cvf_pkg::CVF_CNT_MAX) ? cvf_pkg::CVF_CNT_MAX
            : $past(run_reg[cvf_pkg::CVF_IF_UPPER]) + cvf_pkg::CVF_CNT_ONE))
    else $error("upper port count did not step or saturate");

  // Host interface: trigger read copies and clears.
  a_host_snap_clear: assert property (
    @(posedge mclk) disable iff (!rst_b)
    snap_hit[cvf_pkg::CVF_IF_HOST]
    |=> snap_reg[cvf_pkg::CVF_IF_HOST] == $past(run_reg[cvf_pkg::CVF_IF_HOST])
      && run_reg[cvf_pkg::CVF_IF_HOST]
         == ($past(frame_valid[cvf_pkg::CVF_IF_HOST]) ? cvf_pkg::CVF_CNT_ONE : cvf_pkg::CVF_CNT_ZERO))
    else $error("host snapshot did not copy and clear");

  // Upper chain port: trigger read copies and clears.
  a_upper_snap_clear: assert property (
    @(posedge mclk) disable iff (!rst_b)
    snap_hit[cvf_pkg::CVF_IF_UPPER]
    |=> snap_reg[cvf_pkg::CVF_IF_UPPER] == $past(run_reg[cvf_pkg::CVF_IF_UPPER])
      && run_reg[cvf_pkg::CVF_IF_UPPER]
         == ($past(frame_valid[cvf_pkg::CVF_IF_UPPER]) ? cvf_pkg::CVF_CNT_ONE : cvf_pkg::CVF_CNT_ZERO))
    else $error("upper port snapshot did not copy and clear");

  // Reading a high byte returns bits 15 to 8 of the snapshot one cycle later.
  a_high_byte_read: assert property (
    @(posedge mclk) disable iff (!rst_b)
    rd_hit(bus_req, cvf_pkg::CVF_HIGH_OFS[cvf_pkg::CVF_IF_LOWER])
    |=> rdata == snap_reg[cvf_pkg::CVF_IF_LOWER][cvf_pkg::CVF_HI_MSB:cvf_pkg::CVF_HI_LSB])
    else $error("lower port high byte read returned wrong data");

  // Reading a low byte returns bits 7 to 0 of the snapshot one cycle later.
  a_low_byte_read: assert property (
    @(posedge mclk) disable iff (!rst_b)
    rd_hit(bus_req, cvf_pkg::CVF_LOW_OFS[cvf_pkg::CVF_IF_HOST])
    |=> rdata == snap_reg[cvf_pkg::CVF_IF_HOST][cvf_pkg::CVF_LO_MSB:cvf_pkg::CVF_LO_LSB])
    else $error("host low byte read returned wrong data");

  // A write disturbs neither the upper port snapshot and running count nor the host snapshot.
  a_write_ignored: assert property (
    @(posedge mclk) disable iff (!rst_b)
    bus_req.wr && !(|frame_valid) && !(|snap_hit)
    |=> $stable(snap_reg[cvf_pkg::CVF_IF_UPPER]) && $stable(run_reg[cvf_pkg::CVF_IF_UPPER])
      && $stable(snap_reg[cvf_pkg::CVF_IF_HOST]))
    else $error("a write changed a count register");

  // With no read strobe the read data return to zero next cycle.
  a_idle_rdata_zero: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !bus_req.rd |=> rdata == cvf_pkg::CVF_BYTE_ZERO)
    else $error("read data not zero after an idle cycle");

  // Host interface: no frame, no snapshot, no change.
  a_host_count_idle: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !frame_valid[cvf_pkg::CVF_IF_HOST] && !snap_hit[cvf_pkg::CVF_IF_HOST]
    |=> $stable(run_reg[cvf_pkg::CVF_IF_HOST]))
    else $error("host count moved without a frame");

  // Upper chain port: no frame, no snapshot, no change.
  a_upper_count_idle: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !frame_valid[cvf_pkg::CVF_IF_UPPER] && !snap_hit[cvf_pkg::CVF_IF_UPPER]
    |=> $stable(run_reg[cvf_pkg::CVF_IF_UPPER]))
    else $error("upper port count moved without a frame");

  // Host interface: full scale holds across frames until a snapshot.
  a_host_sat_hold: assert property (
    @(posedge mclk) disable iff (!rst_b)
    run_reg[cvf_pkg::CVF_IF_HOST] == cvf_pkg::CVF_CNT_MAX && !snap_hit[cvf_pkg::CVF_IF_HOST]
    |=> run_reg[cvf_pkg::CVF_IF_HOST] == cvf_pkg::CVF_CNT_MAX)
    else $error("host count left full scale without a snapshot");

  // Upper chain port: full scale holds across frames until a snapshot.
  a_upper_sat_hold: assert property (
    @(posedge mclk) disable iff (!rst_b)
    run_reg[cvf_pkg::CVF_IF_UPPER] == cvf_pkg::CVF_CNT_MAX && !snap_hit[cvf_pkg::CVF_IF_UPPER]
    |=> run_reg[cvf_pkg::CVF_IF_UPPER] == cvf_pkg::CVF_CNT_MAX)
    else $error("upper port count left full scale without a snapshot");

  // Lower chain port: the last frame below full scale lands exactly on full scale.
  a_lower_sat_reach: assert property (
    @(posedge mclk) disable iff (!rst_b)
    frame_valid[cvf_pkg::CVF_IF_LOWER] && !snap_hit[cvf_pkg::CVF_IF_LOWER]
      && run_reg[cvf_pkg::CVF_IF_LOWER] == cvf_pkg::CVF_CNT_MAX - cvf_pkg::CVF_CNT_ONE
    |=> run_reg[cvf_pkg::CVF_IF_LOWER] == cvf_pkg::CVF_CNT_MAX)
    else $error("lower port count did not reach full scale");

  // Host interface: the last frame below full scale lands exactly on full scale.
  a_host_sat_reach: assert property (
    @(posedge mclk) disable iff (!rst_b)
    frame_valid[cvf_pkg::CVF_IF_HOST] && !snap_hit[cvf_pkg::CVF_IF_HOST]
      && run_reg[cvf_pkg::CVF_IF_HOST] == cvf_pkg::CVF_CNT_MAX - cvf_pkg::CVF_CNT_ONE
    |=> run_reg[cvf_pkg::CVF_IF_HOST] == cvf_pkg::CVF_CNT_MAX)
    else $error("host count did not reach full scale");

  // Upper chain port: the last frame below full scale lands exactly on full scale.
  a_upper_sat_reach: assert property (
    @(posedge mclk) disable iff (!rst_b)
    frame_valid[cvf_pkg::CVF_IF_UPPER] && !snap_hit[cvf_pkg::CVF_IF_UPPER]
      && run_reg[cvf_pkg::CVF_IF_UPPER] == cvf_pkg::CVF_CNT_MAX - cvf_pkg::CVF_CNT_ONE
    |=> run_reg[cvf_pkg::CVF_IF_UPPER] == cvf_pkg::CVF_CNT_MAX)
    else $error("upper port count did not reach full scale");

  // Reading the host high byte returns bits 15 to 8 of its snapshot one cycle later.
  a_host_high_read: assert property (
    @(posedge mclk) disable iff (!rst_b)
    rd_hit(bus_req, cvf_pkg::CVF_HIGH_OFS[cvf_pkg::CVF_IF_HOST])
    |=> rdata == snap_reg[cvf_pkg::CVF_IF_HOST][cvf_pkg::CVF_HI_MSB:cvf_pkg::CVF_HI_LSB])
    else $error("host high byte read returned wrong data");

  // Reading the upper port high byte returns bits 15 to 8 of its snapshot one cycle later.
  a_upper_high_read: assert property (
    @(posedge mclk) disable iff (!rst_b)
    rd_hit(bus_req, cvf_pkg::CVF_HIGH_OFS[cvf_pkg::CVF_IF_UPPER])
    |=> rdata == snap_reg[cvf_pkg::CVF_IF_UPPER][cvf_pkg::CVF_HI_MSB:cvf_pkg::CVF_HI_LSB])
    else $error("upper port high byte read returned wrong data");

  // Reading the lower port low byte returns bits 7 to 0 of its snapshot one cycle later.
  a_lower_low_read: assert property (
    @(posedge mclk) disable iff (!rst_b)
    rd_hit(bus_req, cvf_pkg::CVF_LOW_OFS[cvf_pkg::CVF_IF_LOWER])
    |=> rdata == snap_reg[cvf_pkg::CVF_IF_LOWER][cvf_pkg::CVF_LO_MSB:cvf_pkg::CVF_LO_LSB])
    else $error("lower port low byte read returned wrong data");

  // Reading the upper port low byte returns bits 7 to 0 of its snapshot one cycle later.
  a_upper_low_read: assert property (
    @(posedge mclk) disable iff (!rst_b)
    rd_hit(bus_req, cvf_pkg::CVF_LOW_OFS[cvf_pkg::CVF_IF_UPPER])
    |=> rdata == snap_reg[cvf_pkg::CVF_IF_UPPER][cvf_pkg::CVF_LO_MSB:cvf_pkg::CVF_LO_LSB])
    else $error("upper port low byte read returned wrong data");

  // A trigger read itself returns zero; the fresh snapshot is read afterwards.
  a_trigger_reads_zero: assert property (
    @(posedge mclk) disable iff (!rst_b)
    |snap_hit |=> rdata == cvf_pkg::CVF_BYTE_ZERO)
    else $error("trigger read returned nonzero data");

  // A write leaves the lower port snapshot and running count alone.
  a_write_kept_lower: assert property (
    @(posedge mclk) disable iff (!rst_b)
    bus_req.wr && !(|frame_valid) && !(|snap_hit)
    |=> $stable(snap_reg[cvf_pkg::CVF_IF_LOWER]) && $stable(run_reg[cvf_pkg::CVF_IF_LOWER]))
    else $error("a write changed a lower port count register");

  // A read of any place outside the count registers returns zero.
  a_unmapped_read_zero: assert property (
    @(posedge mclk) disable iff (!rst_b)
    bus_req.rd
      && !rd_hit(bus_req, cvf_pkg::CVF_HIGH_OFS[cvf_pkg::CVF_IF_HOST])
      && !rd_hit(bus_req, cvf_pkg::CVF_LOW_OFS[cvf_pkg::CVF_IF_HOST])
      && !rd_hit(bus_req, cvf_pkg::CVF_HIGH_OFS[cvf_pkg::CVF_IF_LOWER])
      && !rd_hit(bus_req, cvf_pkg::CVF_LOW_OFS[cvf_pkg::CVF_IF_LOWER])
      && !rd_hit(bus_req, cvf_pkg::CVF_HIGH_OFS[cvf_pkg::CVF_IF_UPPER])
      && !rd_hit(bus_req, cvf_pkg::CVF_LOW_OFS[cvf_pkg::CVF_IF_UPPER])
    |=> rdata == cvf_pkg::CVF_BYTE_ZERO)
    else $error("unmapped read returned nonzero data");

  // A lower port trigger read leaves the other running counts where they were.
  a_other_runs_kept: assert property (
    @(posedge mclk) disable iff (!rst_b)
    snap_hit[cvf_pkg::CVF_IF_LOWER] && !frame_valid[cvf_pkg::CVF_IF_HOST] && !frame_valid[cvf_pkg::CVF_IF_UPPER]
    |=> $stable(run_reg[cvf_pkg::CVF_IF_HOST]) && $stable(run_reg[cvf_pkg::CVF_IF_UPPER]))
    else $error("lower port trigger disturbed another running count");

endmodule

// File: verif/cvf_frame_src.sv
`timescale 1ns/1ps

// Stands in for the host and the two chain neighbours, and drives one-cycle valid frame pulses.
module cvf_frame_src (
  input  wire logic                           mclk,
  output logic      [cvf_pkg::CVF_NUM_IF-1:0] frame_valid
);

  // Quiet lanes from time zero, so no frame is counted before the first send.
  initial begin
    frame_valid = '0;
  end

  // Holds the chosen lanes high for n back-to-back cycles, which is one frame per cycle.
  task automatic send(input logic [cvf_pkg::CVF_NUM_IF-1:0] lanes, input int n);
    @(posedge mclk);
    frame_valid <= lanes;
    repeat (n - 1) @(posedge mclk);
    @(posedge mclk);
    frame_valid <= '0;
  endtask

endmodule

// File: verif/comm_valid_frame_counters_test.sv
`timescale 1ns/1ps

module comm_valid_frame_counters_test;
  logic                                   mclk;
  logic                                   rst_b;
  cvf_pkg::cvf_bus_req_t                  bus_req;
  wire logic [cvf_pkg::CVF_NUM_IF-1:0]    frame_valid;
  logic      [cvf_pkg::CVF_DATA_W-1:0]    rdata;
  logic      [cvf_pkg::CVF_DATA_W-1:0]    d;
  logic      [cvf_pkg::CVF_CNT_W-1:0]     cnt;
  int                                     mismatches;
  int                                     samples_checked;

  cvf_counters i_cvf_counters (.mclk(mclk), .rst_b(rst_b), .bus_req(bus_req), .frame_valid(frame_valid),
                               .rdata(rdata));
  cvf_frame_src i_cvf_frame_src (.mclk(mclk), .frame_valid(frame_valid));

  // Free-running 10 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Counts every comparison and reports a mismatch at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One read cycle; the data stand only in the cycle after the strobe, so they are sampled there.
  task automatic bus_read(input logic [9:0] a, output logic [7:0] q);
    @(posedge mclk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge mclk);
    bus_req.rd   <= 1'b0;
    #1 q = rdata;
  endtask

  // One write cycle with the strobe beside address and data.
  task automatic bus_write(input logic [9:0] a, input logic [7:0] v);
    @(posedge mclk);
    bus_req.addr  <= a;
    bus_req.wdata <= v;
    bus_req.wr    <= 1'b1;
    @(posedge mclk);
    bus_req.wr    <= 1'b0;
  endtask

  // Takes a snapshot of one interface, then joins its high and low bytes.
  task automatic snap_count(input int i, output logic [15:0] c);
    logic [7:0] q;
    bus_read(cvf_pkg::CVF_SNAP_OFS[i], q);
    check({8'h00, q}, 16'h0000);
    bus_read(cvf_pkg::CVF_HIGH_OFS[i], c[15:8]);
    bus_read(cvf_pkg::CVF_LOW_OFS[i], c[7:0]);
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short well above the longest expected run.
  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    give_verdict();
  end

  initial begin
    rst_b = 1'b0;
    bus_req = '0;
    mismatches = 0;
    samples_checked = 0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    // Writes must leave the zero reset values alone; an unmapped place reads zero.
    for (int i = 0; i < 3; i++) begin
      bus_write(cvf_pkg::CVF_HIGH_OFS[i], 8'hA5);
      bus_write(cvf_pkg::CVF_LOW_OFS[i], 8'h5A);
      snap_count(i, cnt);
      check(cnt, 16'h0000);
    end
    bus_read(10'h3FF, d);
    check({8'h00, d}, 16'h0000);
    $display("test reset_and_writes done");
    // Distinct counts per interface; a snapshot of one leaves the others running.
    i_cvf_frame_src.send(3'h7, 3);
    i_cvf_frame_src.send(3'h2, 254);
    i_cvf_frame_src.send(3'h4, 2);
    snap_count(1, cnt);
    check(cnt, 16'h0101);
    i_cvf_frame_src.send(3'h7, 1);
    snap_count(0, cnt);
    check(cnt, 16'h0004);
    snap_count(2, cnt);
    check(cnt, 16'h0006);
    snap_count(1, cnt);
    check(cnt, 16'h0001);
    $display("test counts_and_snapshots done");
    // Full scale plus two on every lane must stop at the top, and a snapshot then clears it.
    i_cvf_frame_src.send(3'h7, 65537);
    for (int i = 0; i < 3; i++) begin
      snap_count(i, cnt);
      check(cnt, cvf_pkg::CVF_CNT_MAX);
      snap_count(i, cnt);
      check(cnt, 16'h0000);
    end
    $display("test saturation done");
    // A frame in the trigger cycle opens the new interval, and a write to a trigger never snapshots.
    i_cvf_frame_src.send(3'h2, 2);
    fork
      i_cvf_frame_src.send(3'h2, 3);
      bus_read(cvf_pkg::CVF_SNAP_OFS[1], d);
    join
    check({8'h00, d}, 16'h0000);
    bus_read(cvf_pkg::CVF_HIGH_OFS[1], cnt[15:8]);
    bus_read(cvf_pkg::CVF_LOW_OFS[1], cnt[7:0]);
    check(cnt, 16'h0002);
    bus_write(cvf_pkg::CVF_SNAP_OFS[1], 8'hFF);
    snap_count(1, cnt);
    check(cnt, 16'h0003);
    $display("test trigger_edge_cases done");
    give_verdict();
  end

endmodule
